// [logic/oblc_pkg.sv]
// oblc_pkg: constants, types and register map of the option byte loader.
// assumes a single 100 MHz clock shared with the flash read port and the consumers.
package oblc_pkg;

  // ----------------------------------------------------------------
  // flash locations and option byte fields
  // ----------------------------------------------------------------
  localparam int FLASH_AW = 16;
  localparam logic [15:0] OPT_ADDR_PRIMARY = 16'h0000;
  localparam logic [15:0] OPT_ADDR_SECONDARY = 16'h0001;
  localparam logic [7:0] OPT_ERASED = 8'hFF;
  localparam int PRI_WDOG_RESET_SEL = 7;
  localparam int PRI_WDOG_ALWAYS_ON = 6;
  localparam int PRI_OSC_MODE_HI = 5;
  localparam int PRI_OSC_MODE_LO = 4;
  localparam int PRI_BROWNOUT_ALWAYS_ON = 3;
  localparam int PRI_READ_PROTECT = 2;
  localparam int PRI_WRITE_PROTECT = 0;
  localparam int SEC_CRYSTAL_OFF_IN_RESET = 4;

  typedef enum logic [1:0] {
    OSC_EXT_RC = 2'h0,
    OSC_XTAL_LOW = 2'h1,
    OSC_XTAL_MED = 2'h2,
    OSC_XTAL_HIGH = 2'h3
  } oblc_osc_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int XTAL_SETTLE_NS = 2000;
  localparam int XTAL_SETTLE_CYC = (XTAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_BROWNOUT_STOP_OFF = 0;
  localparam int CTRL_SYSCLK_CRYSTAL = 1;
  localparam int CTRL_WDOG_START = 2;
  localparam int STAT_LOAD_DONE = 0;
  localparam int STAT_WDOG_RUN = 1;
  localparam int STAT_BROWNOUT_EN = 2;
  localparam int STAT_CRYSTAL_EN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } oblc_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } oblc_axil_rsp_s;

  typedef struct packed {
    logic wdog_timeout_reset_sel;
    logic [1:0] osc_mode_sel;
    logic crystal_enable;
    logic sysclk_crystal;
    logic brownout_enable;
    logic code_read_allowed;
    logic debug_full_access;
    logic user_flash_write_allowed;
    logic debug_mass_erase_allowed;
  } oblc_cfg_s;

  typedef enum logic [5:0] {
    LD_REQ0 = 6'h01,
    LD_WAIT0 = 6'h02,
    LD_REQ1 = 6'h04,
    LD_WAIT1 = 6'h08,
    XTAL_SETTLE = 6'h10,
    RUN = 6'h20
  } oblc_fsm_e;

  typedef struct packed {
    oblc_fsm_e fsm;
    logic [7:0] opt_primary;
    logic [7:0] opt_secondary;
    logic [15:0] settle_cnt;
    logic core_run;
    logic flash_rd_en;
    logic [15:0] flash_rd_addr;
    logic wdog_run;
    logic brownout_stop_off;
    logic sysclk_sel;
    logic aw_taken;
    logic [11:0] awaddr;
    logic w_taken;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    oblc_axil_rsp_s rsp;
    oblc_cfg_s cfg;
  } oblc_state_s;

endpackage

// [logic/oblc_loader.sv]
// oblc_loader: reads the two option bytes at reset, holds them and drives decoded config.
// assumes flash_rd_* and stop_* come from logic on aclk; AXI4-Lite master on aclk.
//
// Overview of operation
// - configuration comes from flash bytes zero and one
// - primary bit 7 picks watchdog reset or interrupt
// - bit 6 zero: watchdog forced on, undisableable
// - bit 6 one: start on command, stop only by reset or recovery
// - bits 5:4 choose oscillator drive mode
// - bit 3 zero: stop-mode brown-out off if requested
// - bit 3 one: brown-out always protected
// - bit 2 zero blocks code reads, limits debugger
// - bit 0 zero blocks user program and erase
// - bit 0 one permits program and erase
// - secondary bit 4 zero powers crystal for a settle wait before release
// - crystal enable never switches system clock
// - every reset or recovery reloads hidden holding registers
// - load completes before core is released
module oblc_loader #(
  parameter int SETTLE_CYC = oblc_pkg::XTAL_SETTLE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire oblc_pkg::oblc_axil_req_s s_axil_req,
  output oblc_pkg::oblc_axil_rsp_s s_axil_rsp,
  // flash read port
  output logic flash_rd_en,
  output logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  // power events
  input wire logic stop_mode,
  input wire logic stop_recovery,
  // consumers
  output logic core_run,
  output logic wdog_run,
  output oblc_pkg::oblc_cfg_s cfg
);

  oblc_pkg::oblc_state_s st;
  oblc_pkg::oblc_state_s next_st;

  logic wdog_always_on;
  logic brownout_always_on;
  logic crystal_off_in_reset;
  logic in_settle;
  logic wr_fire;
  logic wr_ctrl;
  logic [31:0] rd_word;

  assign wdog_always_on = st.opt_primary[oblc_pkg::PRI_WDOG_ALWAYS_ON];
  assign brownout_always_on = st.opt_primary[oblc_pkg::PRI_BROWNOUT_ALWAYS_ON];
  assign crystal_off_in_reset = st.opt_secondary[oblc_pkg::SEC_CRYSTAL_OFF_IN_RESET];
  assign in_settle = (st.fsm == oblc_pkg::XTAL_SETTLE);
  assign wr_fire = st.aw_taken && st.w_taken && !st.rsp.bvalid;
  assign wr_ctrl = wr_fire && (st.awaddr == oblc_pkg::REG_CTRL) && st.wstrb[0];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axil_req.araddr == oblc_pkg::REG_CTRL) begin
      rd_word[oblc_pkg::CTRL_BROWNOUT_STOP_OFF] = st.brownout_stop_off;
      rd_word[oblc_pkg::CTRL_SYSCLK_CRYSTAL] = st.sysclk_sel;
    end else if (s_axil_req.araddr == oblc_pkg::REG_STATUS) begin
      // holding registers themselves stay hidden, only effects are visible
      rd_word[oblc_pkg::STAT_LOAD_DONE] = st.core_run;
      rd_word[oblc_pkg::STAT_WDOG_RUN] = st.wdog_run;
      rd_word[oblc_pkg::STAT_BROWNOUT_EN] = st.cfg.brownout_enable;
      rd_word[oblc_pkg::STAT_CRYSTAL_EN] = st.cfg.crystal_enable;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.flash_rd_en = 1'b0;

    case (st.fsm)
      oblc_pkg::LD_REQ0: begin
        next_st.flash_rd_en = 1'b1;
        next_st.flash_rd_addr = oblc_pkg::OPT_ADDR_PRIMARY;
        next_st.fsm = oblc_pkg::LD_WAIT0;
      end
      oblc_pkg::LD_WAIT0: begin
        if (flash_rd_valid) begin
          next_st.opt_primary = flash_rd_data;
          next_st.fsm = oblc_pkg::LD_REQ1;
        end
      end
      oblc_pkg::LD_REQ1: begin
        next_st.flash_rd_en = 1'b1;
        next_st.flash_rd_addr = oblc_pkg::OPT_ADDR_SECONDARY;
        next_st.fsm = oblc_pkg::LD_WAIT1;
      end
      oblc_pkg::LD_WAIT1: begin
        if (flash_rd_valid) begin
          next_st.opt_secondary = flash_rd_data;
          // crystal running through reset costs a settle wait
          if (!flash_rd_data[oblc_pkg::SEC_CRYSTAL_OFF_IN_RESET]) begin
            next_st.settle_cnt = 16'(SETTLE_CYC - 1);
            next_st.fsm = oblc_pkg::XTAL_SETTLE;
          end else begin
            next_st.fsm = oblc_pkg::RUN;
            next_st.core_run = 1'b1;
            next_st.wdog_run = !st.opt_primary[oblc_pkg::PRI_WDOG_ALWAYS_ON];
          end
        end
      end
      oblc_pkg::XTAL_SETTLE: begin
        if (st.settle_cnt == 16'h0000) begin
          next_st.fsm = oblc_pkg::RUN;
          next_st.core_run = 1'b1;
          next_st.wdog_run = !wdog_always_on;
        end else begin
          next_st.settle_cnt = st.settle_cnt - 16'h0001;
        end
      end
      oblc_pkg::RUN: begin
        // start only; while running only reset or stop_recovery clears it
        if (wr_ctrl && st.wdata[oblc_pkg::CTRL_WDOG_START]) begin
          next_st.wdog_run = 1'b1;
        end
      end
      default: begin
        next_st.fsm = oblc_pkg::LD_REQ0;
      end
    endcase

    // stop-mode recovery repeats the whole load with the core held
    if (stop_recovery) begin
      next_st.fsm = oblc_pkg::LD_REQ0;
      next_st.core_run = 1'b0;
      next_st.wdog_run = 1'b0;
    end

    // ---------------- decoded configuration ----------------
    next_st.cfg.wdog_timeout_reset_sel = st.opt_primary[oblc_pkg::PRI_WDOG_RESET_SEL];
    next_st.cfg.osc_mode_sel = st.opt_primary[oblc_pkg::PRI_OSC_MODE_HI:oblc_pkg::PRI_OSC_MODE_LO];
    if (st.core_run) begin
      next_st.cfg.crystal_enable = (st.cfg.osc_mode_sel != oblc_pkg::OSC_EXT_RC);
    end else begin
      next_st.cfg.crystal_enable = in_settle;
    end
    // powering the crystal never moves the clock; software must select it
    next_st.cfg.sysclk_crystal = st.sysclk_sel && st.core_run;
    if (brownout_always_on) begin
      next_st.cfg.brownout_enable = 1'b1;
    end else begin
      next_st.cfg.brownout_enable = !(stop_mode && st.brownout_stop_off);
    end
    next_st.cfg.code_read_allowed = st.opt_primary[oblc_pkg::PRI_READ_PROTECT];
    next_st.cfg.debug_full_access = st.opt_primary[oblc_pkg::PRI_READ_PROTECT];
    next_st.cfg.user_flash_write_allowed = st.opt_primary[oblc_pkg::PRI_WRITE_PROTECT];
    next_st.cfg.debug_mass_erase_allowed = 1'b1;

    // ---------------- AXI4-Lite slave ----------------
    if (s_axil_req.awvalid && st.rsp.awready) begin
      next_st.aw_taken = 1'b1;
      next_st.awaddr = s_axil_req.awaddr;
    end
    if (s_axil_req.wvalid && st.rsp.wready) begin
      next_st.w_taken = 1'b1;
      next_st.wdata = s_axil_req.wdata;
      next_st.wstrb = s_axil_req.wstrb;
    end
    if (wr_fire) begin
      next_st.aw_taken = 1'b0;
      next_st.w_taken = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      if (st.awaddr == oblc_pkg::REG_CTRL || st.awaddr == oblc_pkg::REG_STATUS) begin
        next_st.rsp.bresp = oblc_pkg::RESP_OKAY;
      end else begin
        next_st.rsp.bresp = oblc_pkg::RESP_SLVERR;
      end
      if (wr_ctrl) begin
        next_st.brownout_stop_off = st.wdata[oblc_pkg::CTRL_BROWNOUT_STOP_OFF];
        next_st.sysclk_sel = st.wdata[oblc_pkg::CTRL_SYSCLK_CRYSTAL];
      end
    end else if (st.rsp.bvalid && s_axil_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    next_st.rsp.awready = !next_st.aw_taken && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.w_taken && !next_st.rsp.bvalid;

    if (s_axil_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd_word;
      if (s_axil_req.araddr == oblc_pkg::REG_CTRL || s_axil_req.araddr == oblc_pkg::REG_STATUS) begin
        next_st.rsp.rresp = oblc_pkg::RESP_OKAY;
      end else begin
        next_st.rsp.rresp = oblc_pkg::RESP_SLVERR;
      end
    end else if (st.rsp.rvalid && s_axil_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.fsm <= oblc_pkg::LD_REQ0;
      // erased values until the load lands; the core is held anyway
      st.opt_primary <= oblc_pkg::OPT_ERASED;
      st.opt_secondary <= oblc_pkg::OPT_ERASED;
      st.flash_rd_addr <= oblc_pkg::OPT_ADDR_PRIMARY;
      st.cfg.debug_mass_erase_allowed <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axil_rsp = st.rsp;
  assign flash_rd_en = st.flash_rd_en;
  assign flash_rd_addr = st.flash_rd_addr;
  assign core_run = st.core_run;
  assign wdog_run = st.wdog_run;
  assign cfg = st.cfg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_flash_addr_range: assert property (
    flash_rd_en |-> (flash_rd_addr == oblc_pkg::OPT_ADDR_PRIMARY || flash_rd_addr == oblc_pkg::OPT_ADDR_SECONDARY)
  ) else $error("option read outside the two option bytes");

  chk_wdog_forced_on: assert property (
    (core_run && !wdog_always_on) |-> wdog_run
  ) else $error("watchdog not running while forced on");

  // a one-edge reset pulse is a legal stop, so aresetn is required in the antecedent
  chk_wdog_no_stop: assert property (
    (wdog_run && core_run && !stop_recovery && aresetn) |=> wdog_run
  ) else $error("watchdog stopped without reset or recovery");

  chk_osc_decode: assert property (
    (core_run && $past(core_run)) |->
      cfg.osc_mode_sel == $past(st.opt_primary[oblc_pkg::PRI_OSC_MODE_HI:oblc_pkg::PRI_OSC_MODE_LO])
  ) else $error("oscillator mode differs from option byte");

  chk_brownout_hold: assert property (
    ($past(brownout_always_on) && $past(core_run) && $past(aresetn)) |-> cfg.brownout_enable
  ) else $error("brown-out disabled while always-on");

  chk_write_prot: assert property (
    (core_run && $past(core_run)) |->
      cfg.user_flash_write_allowed == $past(st.opt_primary[oblc_pkg::PRI_WRITE_PROTECT])
  ) else $error("flash write permission differs from option byte");

  chk_read_prot: assert property (
    (core_run && $past(core_run)) |->
      cfg.code_read_allowed == $past(st.opt_primary[oblc_pkg::PRI_READ_PROTECT])
  ) else $error("read protection differs from option byte");

  chk_sysclk_manual: assert property (
    cfg.sysclk_crystal |-> $past(st.sysclk_sel)
  ) else $error("system clock moved to crystal without software select");

  chk_reload_seq: assert property (
    (stop_recovery && core_run) |=> !core_run ##1 (flash_rd_en && flash_rd_addr == oblc_pkg::OPT_ADDR_PRIMARY)
  ) else $error("recovery did not restart option load");

  chk_release_after_load: assert property (
    $rose(core_run) |-> ($past(st.fsm) == oblc_pkg::LD_WAIT1 || $past(st.fsm) == oblc_pkg::XTAL_SETTLE)
  ) else $error("core released before option load completed");

  chk_opt_stable: assert property (
    (core_run && $past(core_run)) |-> ($stable(st.opt_primary) && $stable(st.opt_secondary))
  ) else $error("held options changed between resets");

  // the last settle cycle releases the core on the next edge, so core is checked in place
  chk_xtal_in_reset: assert property (
    in_settle |-> (!core_run ##1 cfg.crystal_enable)
  ) else $error("crystal off or core running during settle");

  chk_xtal_off_load: assert property (
    (!core_run && !in_settle) |=> !cfg.crystal_enable
  ) else $error("crystal powered while loading without settle");

  chk_brownout_awake: assert property (
    (core_run && aresetn && !brownout_always_on && !stop_mode) |=> cfg.brownout_enable
  ) else $error("brown-out off outside stop mode");

  chk_mass_erase_open: assert property (
    !cfg.user_flash_write_allowed |-> cfg.debug_mass_erase_allowed
  ) else $error("debugger mass erase blocked with write protection");

  cov_reload: cover property (stop_recovery && core_run ##2 flash_rd_en);
  cov_bo_stop_off: cover property (core_run && !cfg.brownout_enable);
  cov_settle_path: cover property (in_settle ##1 !in_settle ##0 core_run);
  cov_wdog_sw_start: cover property (core_run && !wdog_run ##1 wdog_run);
  cov_ctrl_write: cover property (wr_ctrl);

endmodule

// [sim/oblc_flash_model.sv]
// oblc_flash_model: flash read port answering option byte reads.
// assumes aclk timing; bytes and delay set by the bench.
module oblc_flash_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read port
  input wire logic flash_rd_en,
  input wire logic [15:0] flash_rd_addr,
  output logic [7:0] flash_rd_data,
  output logic flash_rd_valid,
  // contents and pacing
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [3:0] delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic at_one;
  logic [3:0] cnt;
  initial begin
    flash_rd_valid = 1'b0;
    flash_rd_data = 8'h5a;
  end
  // data toggles outside the valid cycle so a stale byte is never trusted
  always @(posedge aclk) begin
    flash_rd_valid <= 1'b0;
    flash_rd_data <= ~flash_rd_data;
    if (!aresetn) begin
      busy <= 1'b0;
    end else if (flash_rd_en) begin
      busy <= 1'b1;
      cnt <= delay;
      at_one <= flash_rd_addr[0];
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      flash_rd_valid <= 1'b1;
      flash_rd_data <= at_one ? byte1 : byte0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// [sim/oblc_loader_tb_top.sv]
// oblc_loader_tb_top: self-checking bench for the option byte loader.
// assumes the hand-over timing; inputs move at rising edges.
module oblc_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic stop_mode = 1'b0;
  logic stop_recovery = 1'b0;
  logic flash_rd_en, flash_rd_valid, core_run, wdog_run;
  logic [15:0] flash_rd_addr;
  logic [7:0] flash_rd_data;
  logic [7:0] b0 = 8'hff;
  logic [7:0] b1 = 8'hff;
  logic [3:0] dly = 4'h0;
  logic [31:0] d;
  logic [1:0] r;
  oblc_pkg::oblc_axil_req_s q = '0;
  oblc_pkg::oblc_axil_rsp_s p;
  oblc_pkg::oblc_cfg_s cfg;
  int errors = 0;
  int n_tests = 0;
  logic [15:0] seen[$];

  always #5 aclk = ~aclk;

  oblc_loader #(.SETTLE_CYC(SETTLE)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axil_req(q), .s_axil_rsp(p),
    .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .flash_rd_valid(flash_rd_valid), .stop_mode(stop_mode), .stop_recovery(stop_recovery),
    .core_run(core_run), .wdog_run(wdog_run), .cfg(cfg));
  oblc_flash_model flash (
    .aclk(aclk), .aresetn(aresetn), .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid),
    .byte0(b0), .byte1(b1), .delay(dly));

  always @(posedge aclk)
    if (flash_rd_en === 1'b1) seen.push_back(flash_rd_addr);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // outputs are read right after an edge, before that edge's updates land
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    q.awvalid <= 1'b1;
    q.awaddr <= a;
    q.wvalid <= 1'b1;
    q.wdata <= v;
    q.wstrb <= 4'hf;
    q.bready <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge aclk);
      if (q.awvalid && p.awready === 1'b1) q.awvalid <= 1'b0;
      if (q.wvalid && p.wready === 1'b1) q.wvalid <= 1'b0;
    end while (p.bvalid !== 1'b1);
    q.bready <= 1'b0;
    rs = p.bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    q.arvalid <= 1'b1;
    q.araddr <= a;
    q.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (p.arready === 1'b1) q.arvalid <= 1'b0;
    end while (p.rvalid !== 1'b1);
    q.rready <= 1'b0;
    v = p.rdata;
    rs = p.rresp;
  endtask

  // reload by reset or recovery; lat counts edges from second byte to core release
  task automatic reload(input logic [7:0] x0, input logic [7:0] x1, input logic [3:0] dl,
                        input bit rst, input int lat);
    int n;
    int k;
    n = 0;
    k = -1;
    @(posedge aclk);
    b0 <= x0;
    b1 <= x1;
    dly <= dl;
    if (rst) aresetn <= 1'b0;
    else stop_recovery <= 1'b1;
    @(posedge aclk);
    aresetn <= 1'b1;
    stop_recovery <= 1'b0;
    seen.delete();
    do begin
      @(posedge aclk);
      n++;
      if (k >= 0) k++;
      if (flash_rd_valid === 1'b1 && flash_rd_addr === 16'h0001) k = 0;
    end while (!(k > 0 && core_run === 1'b1) && n < 200);
    chk("load_latency", lat, k);
    chk("flash_order", {seen[0], seen[1]}, 32'h0000_0001);
    settle();
  endtask

  task automatic test_erased();
    reload(8'hff, 8'hff, 4'h0, 1'b1, 1);
    chk("reset_sel", 1, cfg.wdog_timeout_reset_sel);
    chk("osc_mode", 3, cfg.osc_mode_sel);
    chk("wdog_idle", 0, wdog_run);
    chk("read_ok", 3, {cfg.code_read_allowed, cfg.debug_full_access});
    chk("write_ok", 1, cfg.user_flash_write_allowed);
    chk("sysclk", 0, cfg.sysclk_crystal);
    wr(oblc_pkg::REG_CTRL, 32'h0000_0007, r);
    stop_mode <= 1'b1;
    chk("wr_resp", oblc_pkg::RESP_OKAY, r);
    settle();
    chk("wdog_start", 1, wdog_run);
    chk("sysclk_sel", 1, cfg.sysclk_crystal);
    chk("bo_kept", 1, cfg.brownout_enable);
    rd(oblc_pkg::REG_STATUS, d, r);
    chk("status", 32'h0000_000f, d);
    chk("rd_resp", oblc_pkg::RESP_OKAY, r);
    rd(12'h100, d, r);
    chk("unmapped", oblc_pkg::RESP_SLVERR, r);
    chk("unmapped_data", 0, d);
  endtask

  task automatic test_programmed();
    stop_mode <= 1'b0;
    wr(oblc_pkg::REG_CTRL, 32'h0000_0000, r);
    reload(8'h02, 8'hef, 4'h5, 1'b0, SETTLE + 1);
    chk("xtal_rc", 0, cfg.crystal_enable);
    chk("wdog_forced", 1, wdog_run);
    chk("irq_sel", 0, cfg.wdog_timeout_reset_sel);
    chk("osc_rc", 0, cfg.osc_mode_sel);
    chk("read_blk", 0, {cfg.code_read_allowed, cfg.debug_full_access});
    chk("write_blk", 1, {cfg.user_flash_write_allowed, cfg.debug_mass_erase_allowed});
    wr(oblc_pkg::REG_CTRL, 32'h0000_0001, r);
    settle();
    chk("bo_run", 1, cfg.brownout_enable);
    chk("wdog_kept", 1, wdog_run);
    stop_mode <= 1'b1;
    settle();
    chk("bo_stop", 0, cfg.brownout_enable);
  endtask

  task automatic test_hold();
    @(posedge aclk);
    b0 <= 8'hff;
    repeat (20) @(posedge aclk);
    chk("osc_held", 0, cfg.osc_mode_sel);
    chk("wdog_held", 1, wdog_run);
    reload(8'h7e, 8'hff, 4'h2, 1'b1, 1);
    chk("osc_new", 3, cfg.osc_mode_sel);
    chk("wdog_off", 0, wdog_run);
    chk("wp_new", 0, cfg.user_flash_write_allowed);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    test_erased();
    test_programmed();
    test_hold();
    close_out();
  end

  initial begin
    #(3000 * 10);
    errors++;
    close_out();
  end
endmodule
